/* hw/supply_voltage_reset_monitor.sv */
// Register front end and control logic of the low-voltage detector.
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "lvd_params.svh"
module supply_voltage_reset_monitor (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [3:0] awaddr,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [3:0] araddr,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Analog comparator: one input per sense source, high when supply is below threshold; threshold and enable out
    input wire logic vdd_below,
    input wire logic ext_below,
    output logic [3:0] detect_threshold_voltage,
    output logic comparator_on,
    // System outputs
    output logic internal_reset_req,
    output logic irq
);
    lvd_pkg::ctrl_t ctrl_q, ctrl_d;
    logic [`LEVEL_W-1:0] level_q, level_d;
    logic [1:0] status_q, status_d;
    logic [1:0] mask_q, mask_d;
    lvd_pkg::det_state_t st_q, st_d;
    logic [11:0] cnt_q, cnt_d;
    logic rst_q, rst_d;
    logic have_aw_q, have_aw_d, have_w_q, have_w_d;
    logic [3:0] aw_q, aw_d;
    logic [31:0] wd_q, wd_d;
    logic [3:0] ws_q, ws_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] below_s;
    logic below;
    logic above_flag;
    lvd_pkg::events_t ev;
    logic wr_go;

    lvd_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in({ext_below, vdd_below}),
        .sync_out(below_s)
    );

    // Source select: zero senses the main supply, the reset default. [RULE_02]
    assign below = ctrl_q.src ? below_s[1] : below_s[0];
    // The flag only reports once the comparator has settled, so polling covers the wait. [RULE_05]
    assign above_flag = (st_q == lvd_pkg::ST_RUN) && !below; // [RULE_06]
    assign detect_threshold_voltage = level_q; // [RULE_03]
    assign comparator_on = ctrl_q.enable; // [RULE_04]

    // Each channel is ready while it holds nothing; the write goes once address and data are both held and no write response is pending.
    assign awready = !have_aw_q;
    assign wready = !have_w_q;
    assign wr_go = have_aw_q && have_w_q && !bvalid_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = !rvalid_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    // Detector state: settle timer after enable.
    // The 12-bit counter holds the whole settle wait with room to spare.
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        unique case (st_q)
            lvd_pkg::ST_OFF: begin
                cnt_d = 12'h000;
                if (ctrl_q.enable) begin
                    st_d = lvd_pkg::ST_SETTLE;
                end
            end
            lvd_pkg::ST_SETTLE: begin
                cnt_d = cnt_q + 12'h001;
                if (cnt_q == 12'(`STAB_CYCLES - 1)) begin
                    st_d = lvd_pkg::ST_RUN;
                end
            end
            lvd_pkg::ST_RUN: begin
                cnt_d = 12'h000;
            end
        endcase
        if (!ctrl_q.enable) begin
            st_d = lvd_pkg::ST_OFF;
        end
    end

    // Events: a low supply seen while enabled and not in reset mode interrupts. [RULE_08]
    always_comb begin
        ev.low_det = ctrl_q.enable && !ctrl_q.rmode && below;
        ev.above_det = above_flag;
    end

    // Internal reset only on a low supply in reset mode; selecting reset mode
    // while above threshold leaves it quiet. [RULE_07] [RULE_09] [RULE_12]
    always_comb begin
        // Enable is tested as well as the run state: the state only drops to off
        // one cycle after enable clears, and the request must not outlive a stop
        // that leaves reset mode set.
        rst_d = (st_q == lvd_pkg::ST_RUN)
            && ctrl_q.enable
            && ctrl_q.rmode
            && below;
    end

    // Register writes and the write channel.
    always_comb begin
        ctrl_d = ctrl_q;
        level_d = level_q;
        mask_d = mask_q;
        status_d = status_q;
        have_aw_d = have_aw_q;
        have_w_d = have_w_q;
        aw_d = aw_q;
        wd_d = wd_q;
        ws_d = ws_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (awvalid && awready) begin
            have_aw_d = 1'b1;
            aw_d = awaddr;
        end
        if (wvalid && wready) begin
            have_w_d = 1'b1;
            wd_d = wdata;
            ws_d = wstrb;
        end
        if (bvalid_q && bready) begin
            bvalid_d = 1'b0;
        end
        if (wr_go) begin
            have_aw_d = 1'b0;
            have_w_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = 2'h0;
            // Only the four aligned word offsets are mapped. Decoding the full
            // address keeps a stray byte offset from landing in the control
            // register; with strobe bit 0 set it is answered with a slave error instead.
            if (ws_q[0]) begin
                unique case (aw_q)
                    `OFS_CTRL: begin
                        // A zero byte stops everything in one access; bit writes
                        // are expected to drop reset mode before enable. [RULE_10] [RULE_11]
                        ctrl_d.enable = wd_q[`BIT_EN];
                        ctrl_d.src = wd_q[`BIT_SRC];
                        ctrl_d.rmode = wd_q[`BIT_RMODE];
                    end
                    `OFS_LEVEL: level_d = wd_q[`LEVEL_W-1:0];
                    `OFS_STATUS: status_d = status_q & ~wd_q[1:0];
                    `OFS_MASK: mask_d = wd_q[1:0];
                    default: bresp_d = 2'h2;
                endcase
            end
        end
        // Status bits are sticky; software clears them by writing ones.
        // Hardware set wins over a software clear in the same cycle.
        status_d = status_d | {ev.above_det, ev.low_det};
    end

    // Read channel.
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (rvalid_q && rready) begin
            rvalid_d = 1'b0;
        end
        if (arvalid && arready) begin
            rvalid_d = 1'b1;
            rresp_d = 2'h0;
            rdata_d = 32'h0000_0000;
            // Same full decode as the write side, so an unaligned read also errors.
            unique case (araddr)
                `OFS_CTRL: begin
                    rdata_d[`BIT_EN] = ctrl_q.enable;
                    rdata_d[`BIT_SRC] = ctrl_q.src;
                    rdata_d[`BIT_RMODE] = ctrl_q.rmode;
                    rdata_d[`BIT_FLAG] = above_flag; // [RULE_06]
                end
                `OFS_LEVEL: rdata_d[`LEVEL_W-1:0] = level_q;
                `OFS_STATUS: rdata_d[1:0] = status_q;
                `OFS_MASK: rdata_d[1:0] = mask_q;
                default: rresp_d = 2'h2;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= lvd_pkg::ctrl_t'(3'h0);
            level_q <= `RST_LEVEL;
            // Mask starts set so enabling never interrupts unbidden. [RULE_01]
            mask_q <= `RST_MASK;
            status_q <= 2'h0;
            st_q <= lvd_pkg::ST_OFF;
            cnt_q <= 12'h000;
            rst_q <= 1'b0;
            have_aw_q <= 1'b0;
            have_w_q <= 1'b0;
            aw_q <= 4'h0;
            wd_q <= 32'h0000_0000;
            ws_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= 2'h0;
        end else begin
            ctrl_q <= ctrl_d;
            level_q <= level_d;
            mask_q <= mask_d;
            status_q <= status_d;
            st_q <= st_d;
            cnt_q <= cnt_d;
            rst_q <= rst_d;
            have_aw_q <= have_aw_d;
            have_w_q <= have_w_d;
            aw_q <= aw_d;
            wd_q <= wd_d;
            ws_q <= ws_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    assign internal_reset_req = rst_q;
    // Level interrupt: any set status bit that software has not masked.
    assign irq = |(status_q & ~mask_q); // [RULE_08]
endmodule // supply_voltage_reset_monitor
`default_nettype wire

/* common/lvd_params.svh */
// Constants for the supply voltage reset monitor: offsets, fields, resets, timing.
// Summary of operation
// RULE_01: Software masks detector interrupt before enabling.
// RULE_02: Control bit 2 selects sense source.
// RULE_03: Level register bits 3:0 pick threshold.
// RULE_04: Control bit 7 enables the detector.
// RULE_05: Software waits stabilisation, ten microseconds maximum.
// RULE_06: Control bit 0 reads supply-above flag.
// RULE_07: Control bit 1 selects reset mode.
// RULE_08: Unmasked detector may interrupt right after enable.
// RULE_09: No reset when supply above at selection.
// RULE_10: Byte stop writes zero to control register.
// RULE_11: Bit stop clears reset mode, then enable.
// RULE_12: Enabled reset mode resets on low supply.
`ifndef LVD_PARAMS_SVH
`define LVD_PARAMS_SVH
`define OFS_CTRL 4'h0
`define OFS_LEVEL 4'h4
`define OFS_STATUS 4'h8
`define OFS_MASK 4'hC
`define BIT_FLAG 0
`define BIT_RMODE 1
`define BIT_SRC 2
`define BIT_EN 7
`define LEVEL_W 4
`define RST_CTRL 8'h00
`define RST_LEVEL 4'h0
`define RST_MASK 2'h3
`define STAB_TIME_NS 10000
`define CLK_PERIOD_NS 5
`define STAB_CYCLES (`STAB_TIME_NS / `CLK_PERIOD_NS)
`endif

/* common/lvd_pkg.sv */
// Types shared by the supply voltage reset monitor files.
package lvd_pkg;
    typedef struct packed {
        logic enable;
        logic src;
        logic rmode;
    } ctrl_t;
    typedef enum logic [1:0] {ST_OFF, ST_SETTLE, ST_RUN} det_state_t;
    typedef struct packed {
        logic low_det;
        logic above_det;
    } events_t;
endpackage

/* hw/lvd_sync.sv */
// Two-stage synchroniser for the analog comparator outputs.
`timescale 1ns/1ps
`default_nettype none
module lvd_sync (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Asynchronous level in, synchronised level out
    input wire logic [1:0] async_in,
    output logic [1:0] sync_out
);
    logic [1:0] s1_q;
    logic [1:0] s2_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q <= 2'h0;
            s2_q <= 2'h0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
        end
    end
    assign sync_out = s2_q;
endmodule // lvd_sync
`default_nettype wire

/* bench/lvd_props.sv */
// Concurrent checks on the monitor's bus handshakes and reset request.
`timescale 1ns/1ps
`default_nettype none
module lvd_props (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    // Detector
    input wire logic vdd_below,
    input wire logic ext_below,
    input wire logic comparator_on,
    input wire logic internal_reset_req,
    input wire logic irq
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_req_needs_on: assert property (internal_reset_req |-> $past(comparator_on))
        else $error("reset request while detector was off");
    a_no_reset_above: assert property ((!vdd_below && !ext_below) [*3] |=> !internal_reset_req)
        else $error("reset request with supply above threshold");
    a_stop_drops_req: assert property ($fell(comparator_on) |-> ##[0:2] !internal_reset_req)
        else $error("reset request outlived detector stop");
    a_b_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
        else $error("write response missing");
    a_b_single: assert property (bvalid && bready |=> !bvalid)
        else $error("write response repeated");
    a_r_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read data late");
    a_r_single: assert property (rvalid && rready |=> !rvalid)
        else $error("read data repeated");
    a_ar_refused: assert property (rvalid |-> !arready)
        else $error("read address taken while data pending");
    cover property (internal_reset_req);
    cover property (irq);
    cover property (bvalid && bresp == 2'h2);
    cover property ($fell(comparator_on));
endmodule // lvd_props
bind supply_voltage_reset_monitor lvd_props u_props (
    .aclk(aclk),
    .aresetn(aresetn),
    .awvalid(awvalid),
    .awready(awready),
    .wvalid(wvalid),
    .wready(wready),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .rvalid(rvalid),
    .rready(rready),
    .vdd_below(vdd_below),
    .ext_below(ext_below),
    .comparator_on(comparator_on),
    .internal_reset_req(internal_reset_req),
    .irq(irq)
);
`default_nettype wire

/* bench/supply_voltage_reset_monitor_test.sv */
// Self-checking bench for the supply voltage reset monitor.
`timescale 1ns/1ps
`default_nettype none
`include "lvd_params.svh"
module supply_voltage_reset_monitor_test;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, vdd_below = 1'b0, ext_below = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, comparator_on, internal_reset_req, irq;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF, detect_threshold_voltage;
    logic [31:0] wdata = 32'h0, rdata, v, seed = 32'h00016C01;
    logic [1:0] bresp, rresp;
    int n_fail = 0, total_checks = 0;
    supply_voltage_reset_monitor u_dut (
        .aclk(aclk),
        .aresetn(aresetn),
        .awvalid(awvalid),
        .awready(awready),
        .awaddr(awaddr),
        .wvalid(wvalid),
        .wready(wready),
        .wdata(wdata),
        .wstrb(wstrb),
        .bvalid(bvalid),
        .bready(bready),
        .bresp(bresp),
        .arvalid(arvalid),
        .arready(arready),
        .araddr(araddr),
        .rvalid(rvalid),
        .rready(rready),
        .rdata(rdata),
        .rresp(rresp),
        .vdd_below(vdd_below),
        .ext_below(ext_below),
        .detect_threshold_voltage(detect_threshold_voltage),
        .comparator_on(comparator_on),
        .internal_reset_req(internal_reset_req),
        .irq(irq)
    );
    always #2.5 aclk = ~aclk;
    task results;
        if (n_fail == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Argument packs enable, source, reset mode and flag.
    function logic [31:0] ctrl_val(input logic [3:0] c);
        return {24'h0, c[3], 4'h0, c[2:0]};
    endfunction
    task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        logic pa, pw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        while (pa || pw) begin
            @(posedge aclk);
            pa = pa && !awready;
            pw = pw && !wready;
            awvalid <= pa;
            wvalid <= pw;
        end
        while (!bvalid) @(posedge aclk);
        chk({30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        chk(rdata, e);
        // Aligned word offsets answer OKAY, any other byte address a slave error.
        chk({30'h0, rresp}, (a[1:0] == 2'h0) ? 32'h0 : 32'h2);
        rready <= 1'b0;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        results;
    end
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`OFS_CTRL, ctrl_val(4'h0));
        rd(`OFS_LEVEL, 32'h0);
        rd(`OFS_STATUS, 32'h0);
        rd(`OFS_MASK, 32'h3);
        wr(4'h2, 32'h0, 2'h2);
        rd(4'h6, 32'h0);
        wr(`OFS_CTRL, ctrl_val(4'h4), 2'h0);
        rd(`OFS_CTRL, ctrl_val(4'h4));
        for (int i = 0; i < 5; i++) begin
            v = (i == 0) ? 32'hF : xs();
            wr(`OFS_LEVEL, v, 2'h0);
            rd(`OFS_LEVEL, v & 32'hF);
            chk({28'h0, detect_threshold_voltage}, v & 32'hF);
        end
        wr(`OFS_MASK, 32'h3, 2'h0);
        wr(`OFS_CTRL, ctrl_val(4'h8), 2'h0);
        chk({31'h0, comparator_on}, 32'h1);
        rd(`OFS_CTRL, ctrl_val(4'h8));
        repeat (`STAB_CYCLES + 10) @(posedge aclk);
        rd(`OFS_CTRL, ctrl_val(4'h9));
        // Only the low-supply event is unmasked, so the above event cannot hold irq up.
        wr(`OFS_MASK, 32'h2, 2'h0);
        vdd_below <= 1'b1;
        repeat (4) @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        vdd_below <= 1'b0;
        repeat (4) @(posedge aclk);
        wr(`OFS_STATUS, 32'h1, 2'h0);
        chk({31'h0, irq}, 32'h0);
        wr(`OFS_CTRL, ctrl_val(4'hA), 2'h0);
        repeat (4) @(posedge aclk);
        chk({31'h0, internal_reset_req}, 32'h0);
        vdd_below <= 1'b1;
        repeat (4) @(posedge aclk);
        chk({31'h0, internal_reset_req}, 32'h1);
        wr(`OFS_CTRL, ctrl_val(4'h0), 2'h0);
        repeat (2) @(posedge aclk);
        chk({31'h0, internal_reset_req}, 32'h0);
        chk({31'h0, comparator_on}, 32'h0);
        // Restart masked with the supply low, then stop one bit at a time.
        wr(`OFS_MASK, 32'h3, 2'h0);
        wr(`OFS_CTRL, ctrl_val(4'h8), 2'h0);
        repeat (`STAB_CYCLES + 10) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        wr(`OFS_CTRL, ctrl_val(4'hA), 2'h0);
        repeat (4) @(posedge aclk);
        chk({31'h0, internal_reset_req}, 32'h1);
        wr(`OFS_CTRL, ctrl_val(4'h8), 2'h0);
        repeat (2) @(posedge aclk);
        chk({31'h0, internal_reset_req}, 32'h0);
        chk({31'h0, comparator_on}, 32'h1);
        wr(`OFS_CTRL, ctrl_val(4'h0), 2'h0);
        chk({31'h0, comparator_on}, 32'h0);
        // Only the alternate source is low; once selected and left unmasked it
        // interrupts straight after enable.
        vdd_below <= 1'b0;
        ext_below <= 1'b1;
        wr(`OFS_STATUS, 32'h3, 2'h0);
        wr(`OFS_MASK, 32'h2, 2'h0);
        chk({31'h0, irq}, 32'h0);
        wr(`OFS_CTRL, ctrl_val(4'hC), 2'h0);
        repeat (4) @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        wr(`OFS_CTRL, ctrl_val(4'h0), 2'h0);
        results;
    end
endmodule // supply_voltage_reset_monitor_test
`default_nettype wire
